//--- rtl/fault_address_capture.sv
// Holds the two fault address registers and their valid flags.
// Assumes fault events are one-cycle pulses from logic on the same clock.
`timescale 1ns/100ps
module fault_address_capture
  import fault_report_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  fault_capture_if.capture cap
);
  logic [31:0] mm_addr_reg;
  logic [31:0] bus_addr_reg;
  logic mm_valid_reg;
  logic bus_valid_reg;

  // ----------------------------------------
  // Address registers
  // ----------------------------------------
  // Every new fault overwrites, even inside a running handler
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mm_addr_reg <= ADDR_RESET;
    else if (cap.mm_event)
      mm_addr_reg <= cap.mm_addr;
    else if (cap.wr_mm_addr)
      mm_addr_reg <= cap.wdata;
  end

  // Requested address is kept, not the split address that erred
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      bus_addr_reg <= ADDR_RESET;
    else if (cap.bus_event && cap.bus_addr_known)
      bus_addr_reg <= cap.bus_addr;
    else if (cap.wr_bus_addr)
      bus_addr_reg <= cap.wdata;
  end

  // ----------------------------------------
  // Valid flags
  // ----------------------------------------
  // Capture wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mm_valid_reg <= 1'b0;
    else if (cap.mm_event)
      mm_valid_reg <= 1'b1;
    else if (cap.clr_mm_valid || cap.wr_mm_addr)
      mm_valid_reg <= 1'b0;
  end

  // A later fault of another kind drops the bus address validity
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      bus_valid_reg <= 1'b0;
    else if (cap.bus_event && cap.bus_addr_known)
      bus_valid_reg <= 1'b1;
    else if (cap.bus_event || cap.other_event || cap.mm_event || cap.clr_bus_valid || cap.wr_bus_addr)
      bus_valid_reg <= 1'b0;
  end

  assign cap.mm_addr_q = mm_addr_reg;
  assign cap.bus_addr_q = bus_addr_reg;
  assign cap.mm_valid = mm_valid_reg;
  assign cap.bus_valid = bus_valid_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  mm_capture_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cap.mm_event |=> (mm_addr_reg == $past(cap.mm_addr)) && mm_valid_reg)
    else $error("memory fault address not captured");
  bus_capture_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (cap.bus_event && cap.bus_addr_known) |=> (bus_addr_reg == $past(cap.bus_addr)) && bus_valid_reg)
    else $error("bus fault address not captured");
  bus_valid_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (cap.mm_event && !cap.bus_event) |=> !bus_valid_reg)
    else $error("bus address valid kept after memory fault");
  mm_valid_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (mm_valid_reg && !cap.mm_event && !cap.wr_mm_addr) |=> $stable(mm_addr_reg))
    else $error("memory fault address changed while valid");
endmodule // fault_address_capture

//--- rtl/fault_capture_if.sv
// Carrier between the register front end and the fault address capture module.
// Assumes both ends run on the same processor clock.
`timescale 1ns/100ps
interface fault_capture_if;
  logic mm_event;
  logic [31:0] mm_addr;
  logic bus_event;
  logic bus_addr_known;
  logic [31:0] bus_addr;
  logic other_event;
  logic wr_mm_addr;
  logic wr_bus_addr;
  logic [31:0] wdata;
  logic clr_mm_valid;
  logic clr_bus_valid;
  logic [31:0] mm_addr_q;
  logic [31:0] bus_addr_q;
  logic mm_valid;
  logic bus_valid;
  modport ctrl (output mm_event, mm_addr, bus_event, bus_addr_known, bus_addr, other_event,
                output wr_mm_addr, wr_bus_addr, wdata, clr_mm_valid, clr_bus_valid,
                input mm_addr_q, bus_addr_q, mm_valid, bus_valid);
  modport capture (input mm_event, mm_addr, bus_event, bus_addr_known, bus_addr, other_event,
                   input wr_mm_addr, wr_bus_addr, wdata, clr_mm_valid, clr_bus_valid,
                   output mm_addr_q, bus_addr_q, mm_valid, bus_valid);
endinterface

//--- rtl/fault_report_pkg.sv
// Package for the fault reporting unit: register map, field positions, access sizes.
// Assumes the unit sits in the processor clock domain behind the private peripheral port.
package fault_report_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] BLOCK_BASE = 32'he000ed00;
  localparam logic [7:0] OFF_CFG_STATUS = 8'h28;
  localparam logic [7:0] OFF_HARD_FLAGS = 8'h2c;
  localparam logic [7:0] OFF_MEM_ADDR = 8'h34;
  localparam logic [7:0] OFF_BUS_ADDR = 8'h38;
  localparam logic [31:0] HARD_FLAGS_RESET = 32'h00000000;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DEBUG_RESERVED_BIT = 31;
  localparam int FORCED_BIT = 30;
  localparam int VECT_TABLE_BIT = 1;
  localparam int MEM_VALID_BIT = 7;
  localparam int BUS_VALID_BIT = 15;
  localparam logic [31:0] HARD_FLAGS_MASK = 32'h40000002;
  // ----------------------------------------
  // Access sizes
  // ----------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
endpackage

//--- rtl/fault_report_unit.sv
// Fault reporting unit: hard fault cause flags and fault address registers.
// Assumes a single-cycle private peripheral port and fault events from the core on the same clock.
// Operation
// - Hard fault flags read normally; writing one clears a flag, zero keeps it.
// - Escalation of an untakeable configurable-priority fault sets the forced flag.
// - Vector table read bus error sets its flag and goes to hard fault.
// - On vector table fault the stacked return address is the preempted instruction.
// - Memory fault address register captures faulting address with its valid flag.
// - Unaligned memory fault captures the exact split access address.
// - Bus fault address register captures faulting address with its valid flag.
// - Unaligned bus fault captures the address the instruction requested.
// - Configurable status takes byte, halfword or word; others only aligned words.
// - A preempting fault may overwrite either fault address register.
// - Registers decode at offsets from the fixed block base address.
// - Only privileged accesses reach these registers.
// - Bus address valid sets after bus fault with known address; other faults clear.
// - Memory address valid reads one only while a faulting address is held.
`timescale 1ns/100ps
module fault_report_unit
  import fault_report_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic bus_sel_i,
  input wire logic bus_write_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic [1:0] bus_size_i,
  input wire logic bus_priv_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  output logic bus_err_o,
  input wire logic escalate_i,
  input wire logic vector_read_err_i,
  input wire logic [31:0] preempted_pc_i,
  input wire logic mm_fault_i,
  input wire logic [31:0] mm_fault_addr_i,
  input wire logic bus_fault_i,
  input wire logic bus_addr_known_i,
  input wire logic [31:0] bus_req_addr_i,
  input wire logic other_fault_i,
  output logic hard_fault_req_o,
  output logic [31:0] stacked_pc_o
);
  fault_capture_if cap_if ();

  logic forced_reg;
  logic vect_tbl_reg;
  logic [7:0] off;
  logic in_block;
  logic sel_cfg;
  logic sel_hard;
  logic sel_mem;
  logic sel_bus;
  logic word_ok;
  logic sub_ok;
  logic acc_ok;
  logic wr_ok;
  logic [3:0] be;
  logic [31:0] hard_flags;
  logic [31:0] read_word;

  // Byte lanes touched by an access of a given size and low address
  function automatic logic [3:0] lane_enable(input logic [1:0] size, input logic [1:0] low);
    logic [3:0] lanes;
    lanes = 4'h0;
    case (size)
      SZ_BYTE: lanes = 4'h1 << low;
      SZ_HALF: lanes = low[1] ? 4'hc : 4'h3;
      SZ_WORD: lanes = 4'hf;
      default: lanes = 4'h0;
    endcase
    return lanes;
  endfunction

  // ----------------------------------------
  // Address decode and access check
  // ----------------------------------------
  // Unaligned or wrongly sized accesses are refused outright, no partial update
  always_comb
  begin
    off = bus_addr_i[7:0];
    in_block = (bus_addr_i[31:8] == BLOCK_BASE[31:8]);
    sel_cfg = (off[7:2] == OFF_CFG_STATUS[7:2]);
    sel_hard = (off == OFF_HARD_FLAGS);
    sel_mem = (off == OFF_MEM_ADDR);
    sel_bus = (off == OFF_BUS_ADDR);
    word_ok = (bus_size_i == SZ_WORD) && (off[1:0] == 2'h0);
    sub_ok = (bus_size_i == SZ_BYTE) || ((bus_size_i == SZ_HALF) && !off[0]) || word_ok;
    acc_ok = bus_sel_i && in_block && bus_priv_i
             && ((sel_cfg && sub_ok) || ((sel_hard || sel_mem || sel_bus) && word_ok));
    wr_ok = acc_ok && bus_write_i;
    be = lane_enable(bus_size_i, off[1:0]);
  end

  // ----------------------------------------
  // Hard fault cause flags
  // ----------------------------------------
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      forced_reg <= HARD_FLAGS_RESET[FORCED_BIT];
    else if (escalate_i)
      forced_reg <= 1'b1;
    else if (wr_ok && sel_hard && bus_wdata_i[FORCED_BIT])
      forced_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      vect_tbl_reg <= HARD_FLAGS_RESET[VECT_TABLE_BIT];
    else if (vector_read_err_i)
      vect_tbl_reg <= 1'b1;
    else if (wr_ok && sel_hard && bus_wdata_i[VECT_TABLE_BIT])
      vect_tbl_reg <= 1'b0;
  end

  // Vector table errors always go to hard fault, as do escalations
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      hard_fault_req_o <= 1'b0;
    else
      hard_fault_req_o <= vector_read_err_i || escalate_i;
  end

  // Return address of the preempted instruction goes onto the stack frame
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      stacked_pc_o <= ADDR_RESET;
    else if (vector_read_err_i)
      stacked_pc_o <= preempted_pc_i;
  end

  // Debug bit and reserved bits are never stored, so they read zero
  always_comb
  begin
    hard_flags = 32'h00000000;
    hard_flags[FORCED_BIT] = forced_reg;
    hard_flags[VECT_TABLE_BIT] = vect_tbl_reg;
    hard_flags = hard_flags & HARD_FLAGS_MASK;
  end

  // ----------------------------------------
  // Fault address capture
  // ----------------------------------------
  assign cap_if.mm_event = mm_fault_i;
  assign cap_if.mm_addr = mm_fault_addr_i;
  assign cap_if.bus_event = bus_fault_i;
  assign cap_if.bus_addr_known = bus_addr_known_i;
  assign cap_if.bus_addr = bus_req_addr_i;
  assign cap_if.other_event = other_fault_i || escalate_i || vector_read_err_i;
  assign cap_if.wr_mm_addr = wr_ok && sel_mem;
  assign cap_if.wr_bus_addr = wr_ok && sel_bus;
  assign cap_if.wdata = bus_wdata_i;
  // Handler drops a stale valid flag by writing one to it
  assign cap_if.clr_mm_valid = wr_ok && sel_cfg && be[0] && bus_wdata_i[MEM_VALID_BIT];
  assign cap_if.clr_bus_valid = wr_ok && sel_cfg && be[1] && bus_wdata_i[BUS_VALID_BIT];

  fault_address_capture u_capture (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .cap(cap_if.capture)
  );

  // ----------------------------------------
  // Read data and error answer
  // ----------------------------------------
  // Only the two valid flags of the configurable status live here; other bits read zero
  always_comb
  begin
    read_word = 32'h00000000;
    if (sel_hard)
      read_word = hard_flags;
    else if (sel_mem)
      read_word = cap_if.mm_addr_q;
    else if (sel_bus)
      read_word = cap_if.bus_addr_q;
    else if (sel_cfg)
    begin
      read_word[MEM_VALID_BIT] = cap_if.mm_valid;
      read_word[BUS_VALID_BIT] = cap_if.bus_valid;
    end
  end

  // Answer one cycle after the request; refused accesses read zero and flag an error
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bus_rdata_o <= 32'h00000000;
      bus_err_o <= 1'b0;
    end
    else
    begin
      bus_rdata_o <= (acc_ok && !bus_write_i) ? read_word : 32'h00000000;
      bus_err_o <= bus_sel_i && !acc_ok;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  forced_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    escalate_i |=> forced_reg && hard_fault_req_o)
    else $error("forced flag not set on escalation");
  vect_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    vector_read_err_i |=> vect_tbl_reg && hard_fault_req_o)
    else $error("vector table flag or hard fault missing");
  flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_ok && sel_hard && bus_wdata_i[FORCED_BIT] && !escalate_i) |=> !forced_reg)
    else $error("write one did not clear forced flag");
  flag_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (vect_tbl_reg && !(wr_ok && sel_hard && bus_wdata_i[VECT_TABLE_BIT])) |=> vect_tbl_reg)
    else $error("vector table flag lost without write one");
  reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (acc_ok && !bus_write_i && sel_hard) |=> ((bus_rdata_o & ~HARD_FLAGS_MASK) == 32'h00000000))
    else $error("reserved flag bits read nonzero");
  priv_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_sel_i && !bus_priv_i) |=> bus_err_o && (bus_rdata_o == 32'h00000000))
    else $error("unprivileged access not refused");
  size_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_sel_i && in_block && sel_mem && bus_size_i != SZ_WORD && !mm_fault_i)
      |=> bus_err_o && $stable(cap_if.mm_addr_q))
    else $error("narrow access to word register not refused");
  stacked_pc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    vector_read_err_i |=> stacked_pc_o == $past(preempted_pc_i))
    else $error("stacked return address wrong");
endmodule // fault_report_unit

//--- verification/test_hard_fault_status_and_fault_address.sv
// Testbench for the fault reporting unit: register port accesses and fault event pulses.
// Assumes the single-cycle register port and one-cycle answer described for fault_report_unit.
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module test_hard_fault_status_and_fault_address
  import fault_report_pkg::*;
;
  // ----------------------------------------
  // Signals and expected field values
  // ----------------------------------------
  localparam logic [31:0] F_FORCED = 32'h1 << FORCED_BIT;
  localparam logic [31:0] F_VT = 32'h1 << VECT_TABLE_BIT;
  localparam logic [31:0] V_MEM = 32'h1 << MEM_VALID_BIT;
  localparam logic [31:0] V_BUS = 32'h1 << BUS_VALID_BIT;
  logic ref_clk_i, rst_b_i, bus_sel_i, bus_write_i, bus_priv_i, bus_err_o, hard_fault_req_o;
  logic [31:0] bus_addr_i, bus_wdata_i, bus_rdata_o, preempted_pc_i, mm_fault_addr_i, bus_req_addr_i;
  logic [31:0] stacked_pc_o;
  logic [1:0] bus_size_i;
  logic escalate_i, vector_read_err_i, mm_fault_i, bus_fault_i, bus_addr_known_i, other_fault_i;
  int n_mismatch = 0;
  int n_tests = 0;
  fault_report_unit i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_sel_i(bus_sel_i),
    .bus_write_i(bus_write_i), .bus_addr_i(bus_addr_i), .bus_size_i(bus_size_i), .bus_priv_i(bus_priv_i),
    .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .bus_err_o(bus_err_o), .escalate_i(escalate_i),
    .vector_read_err_i(vector_read_err_i), .preempted_pc_i(preempted_pc_i), .mm_fault_i(mm_fault_i),
    .mm_fault_addr_i(mm_fault_addr_i), .bus_fault_i(bus_fault_i), .bus_addr_known_i(bus_addr_known_i),
    .bus_req_addr_i(bus_req_addr_i), .other_fault_i(other_fault_i), .hard_fault_req_o(hard_fault_req_o),
    .stacked_pc_o(stacked_pc_o));
  // ----------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole sequence is well under 200 cycles; 2000 leaves room without hiding a hang
  initial
  begin
    #(20 * 2000);
    n_mismatch++;
    end_of_test();
  end
  // ----------------------------------------
  // Access and event tasks
  // ----------------------------------------
  // One register access, held through the taking edge; answer checked in the following cycle
  task automatic acc(input logic wr, input logic [31:0] ad, input logic [1:0] sz, input logic pr,
                     input logic [31:0] wd, input logic [31:0] er, input logic ee);
    @(posedge ref_clk_i);
    bus_sel_i <= 1'b1;
    bus_write_i <= wr;
    bus_addr_i <= ad;
    bus_size_i <= sz;
    bus_priv_i <= pr;
    bus_wdata_i <= wd;
    @(posedge ref_clk_i);
    bus_sel_i <= 1'b0;
    #1;
    `CHK(bus_rdata_o, er)
    `CHK(bus_err_o, ee)
  endtask
  // Event bits: 0 escalate, 1 vector error, 2 mm fault, 3 bus fault, 4 address known, 5 other
  task automatic fire(input logic [5:0] ev, input logic [31:0] a, input logic eh);
    @(posedge ref_clk_i);
    {other_fault_i, bus_addr_known_i, bus_fault_i, mm_fault_i, vector_read_err_i, escalate_i} <= ev;
    mm_fault_addr_i <= a;
    bus_req_addr_i <= a;
    preempted_pc_i <= a;
    @(posedge ref_clk_i);
    {other_fault_i, bus_addr_known_i, bus_fault_i, mm_fault_i, vector_read_err_i, escalate_i} <= 6'h00;
    #1;
    `CHK(hard_fault_req_o, eh)
  endtask
  task automatic rd(input logic [7:0] off, input logic [31:0] er);
    acc(1'b0, BLOCK_BASE | off, SZ_WORD, 1'b1, 32'h0, er, 1'b0);
  endtask
  task automatic wr(input logic [7:0] off, input logic [1:0] sz, input logic [31:0] wd);
    acc(1'b1, BLOCK_BASE | off, sz, 1'b1, wd, 32'h0, 1'b0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {bus_sel_i, bus_write_i, bus_priv_i, bus_size_i, bus_addr_i, bus_wdata_i} = '0;
    {escalate_i, vector_read_err_i, mm_fault_i, bus_fault_i, bus_addr_known_i, other_fault_i} = '0;
    {preempted_pc_i, mm_fault_addr_i, bus_req_addr_i} = '0;
    rst_b_i = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(OFF_HARD_FLAGS, HARD_FLAGS_RESET);
    rd(OFF_CFG_STATUS, 32'h0);
    // Unaligned faulting split address is kept exactly
    fire(6'h04, 32'h20001003, 1'b0);
    rd(OFF_MEM_ADDR, 32'h20001003);
    rd(OFF_CFG_STATUS, V_MEM);
    fire(6'h18, 32'h20002001, 1'b0);
    rd(OFF_BUS_ADDR, 32'h20002001);
    rd(OFF_CFG_STATUS, V_MEM | V_BUS);
    fire(6'h20, 32'h0, 1'b0);
    rd(OFF_CFG_STATUS, V_MEM);
    fire(6'h18, 32'h20003000, 1'b0);
    fire(6'h04, 32'h20004002, 1'b0);
    rd(OFF_MEM_ADDR, 32'h20004002);
    rd(OFF_CFG_STATUS, V_MEM);
    // Status byte and halfword reads return the whole word lanes
    acc(1'b0, BLOCK_BASE | 8'h29, SZ_BYTE, 1'b1, 32'h0, V_MEM, 1'b0);
    acc(1'b0, BLOCK_BASE | 8'h28, SZ_HALF, 1'b1, 32'h0, V_MEM, 1'b0);
    wr(OFF_MEM_ADDR, SZ_WORD, 32'h12345678);
    rd(OFF_MEM_ADDR, 32'h12345678);
    rd(OFF_CFG_STATUS, 32'h0);
    // Write one clears each valid flag from its own byte lane; unknown bus address drops bus valid
    fire(6'h04, 32'h20005004, 1'b0);
    fire(6'h18, 32'h20006008, 1'b0);
    wr(OFF_CFG_STATUS, SZ_BYTE, V_MEM);
    rd(OFF_CFG_STATUS, V_BUS);
    acc(1'b1, BLOCK_BASE | 8'h29, SZ_BYTE, 1'b1, V_BUS, 32'h0, 1'b0);
    rd(OFF_CFG_STATUS, 32'h0);
    fire(6'h18, 32'h2000700c, 1'b0);
    fire(6'h08, 32'h20008000, 1'b0);
    rd(OFF_BUS_ADDR, 32'h2000700c);
    rd(OFF_CFG_STATUS, 32'h0);
    fire(6'h01, 32'h0, 1'b1);
    rd(OFF_HARD_FLAGS, F_FORCED);
    rd(OFF_CFG_STATUS, 32'h0);
    fire(6'h02, 32'h08000124, 1'b1);
    `CHK(stacked_pc_o, 32'h08000124)
    rd(OFF_HARD_FLAGS, F_FORCED | F_VT);
    // Refused accesses leave the flags alone: unprivileged, wrong size, unaligned, unmapped, outside
    acc(1'b1, BLOCK_BASE | OFF_HARD_FLAGS, SZ_WORD, 1'b0, F_FORCED | F_VT, 32'h0, 1'b1);
    acc(1'b0, BLOCK_BASE | OFF_HARD_FLAGS, SZ_WORD, 1'b0, 32'h0, 32'h0, 1'b1);
    acc(1'b1, BLOCK_BASE | OFF_HARD_FLAGS, SZ_HALF, 1'b1, F_FORCED | F_VT, 32'h0, 1'b1);
    acc(1'b0, BLOCK_BASE | OFF_HARD_FLAGS, 2'h3, 1'b1, 32'h0, 32'h0, 1'b1);
    acc(1'b0, BLOCK_BASE | 8'h2e, SZ_WORD, 1'b1, 32'h0, 32'h0, 1'b1);
    acc(1'b0, BLOCK_BASE | 8'h29, SZ_HALF, 1'b1, 32'h0, 32'h0, 1'b1);
    acc(1'b0, BLOCK_BASE | 8'h30, SZ_WORD, 1'b1, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 32'he000ec2c, SZ_WORD, 1'b1, F_FORCED | F_VT, 32'h0, 1'b1);
    rd(OFF_HARD_FLAGS, F_FORCED | F_VT);
    // Clear behaviour: reserved ones and zeros do nothing, one clears only its own flag
    wr(OFF_HARD_FLAGS, SZ_WORD, 32'h3ffffffd);
    rd(OFF_HARD_FLAGS, F_FORCED | F_VT);
    wr(OFF_HARD_FLAGS, SZ_WORD, 32'h0);
    rd(OFF_HARD_FLAGS, F_FORCED | F_VT);
    wr(OFF_HARD_FLAGS, SZ_WORD, F_VT);
    rd(OFF_HARD_FLAGS, F_FORCED);
    wr(OFF_HARD_FLAGS, SZ_WORD, F_FORCED);
    rd(OFF_HARD_FLAGS, 32'h0);
    // Second reset in mid-run wipes a freshly set flag
    fire(6'h01, 32'h0, 1'b1);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(OFF_HARD_FLAGS, HARD_FLAGS_RESET);
    end_of_test();
  end
endmodule // test_hard_fault_status_and_fault_address
